// File: hw/css_contact_sequence_sender.sv
// contact sequence sender: event recognition, sequence and cyclic replay, ahb-lite registers
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
module css_contact_sequence_sender import css_pkg::*; #(
	parameter int unsigned TICK_CYCLES = CSS_TICK_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// contact and operation events, voltage present
	input wire logic contact_closed_i,
	input wire logic short_op_i,
	input wire logic long_op_i,
	input wire logic power_ok_i,
	// telegram requests towards the bus
	output logic tx_valid_o,
	output logic [1:0] tx_obj_o,
	output logic tx_event_o,
	output logic tx_cyclic_o
);
	// configuration registers
	logic mode_q, mode_d;
	logic recov_q, recov_d;
	logic [15:0] per_closed_q, per_closed_d;
	logic [15:0] per_open_q, per_open_d;
	logic [3:0] en_q, en_d;
	logic [3:0] cyc_closed_q, cyc_closed_d;
	logic [3:0] cyc_open_q, cyc_open_d;
	logic [3:0] snd_closed_q, snd_closed_d;
	logic [3:0] snd_open_q, snd_open_d;
	logic [15:0] delay_q [CSS_NUM_OBJ];
	logic [15:0] delay_d [CSS_NUM_OBJ];
	// bus data phase state
	logic dp_wr_q, dp_wr_d;
	logic [7:0] dp_addr_q, dp_addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic hreadyout_q, hreadyout_d;
	logic hresp_q, hresp_d;
	// sequencer state
	css_seq_state_t st_q, st_d;
	logic evt_q, evt_d;
	logic full_q, full_d;
	logic nodelay_q, nodelay_d;
	logic [1:0] idx_q, idx_d;
	logic [15:0] dly_q, dly_d;
	logic cyc_on_q, cyc_on_d;
	logic [15:0] cyc_cnt_q, cyc_cnt_d;
	logic saved_contact_q, saved_contact_d;
	logic saved_valid_q, saved_valid_d;
	logic last_op_q, last_op_d;
	logic op_valid_q, op_valid_d;
	logic contact_prev_q, contact_prev_d;
	logic power_prev_q, power_prev_d;
	logic tx_valid_q, tx_valid_d;
	logic [1:0] tx_obj_q, tx_obj_d;
	logic tx_event_q, tx_event_d;
	logic tx_cyclic_q, tx_cyclic_d;
	// helpers
	logic contact_s;
	logic power_s;
	logic tick;
	logic tick_restart;

	// contact and voltage pins pass two flip-flops, the operation pins go straight in
	css_sync2 u_sync_contact (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i(contact_closed_i),
		.sync_o(contact_s)
	);
	css_sync2 u_sync_power (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i(power_ok_i),
		.sync_o(power_s)
	);

	// time base for delays and cycle periods
	css_sec_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.restart_i(tick_restart),
		.tick_o(tick)
	);

	// a period of zero is not allowed, raise it to the minimum
	function automatic logic [15:0] clamp_period(input logic [31:0] v);
		clamp_period = (v[15:0] < CSS_PERIOD_MIN) ? CSS_PERIOD_MIN : v[15:0];
	endfunction

	// choose the closed/short or open/long variant of a mask
	function automatic logic [3:0] pick4(input logic evt, input logic [3:0] closed, input logic [3:0] open);
		pick4 = (evt == CSS_EVT_OPEN) ? open : closed;
	endfunction

	// object i goes out in this pass
	function automatic logic will_send(input logic [3:0] en, input logic [3:0] snd, input logic [3:0] cyc,
		input logic full, input logic [1:0] i);
		will_send = en[i] & snd[i] & (full | cyc[i]);
	endfunction

	// register read mux
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			CSS_OFF_CTRL: begin
				r[CSS_CTRL_MODE_BIT] = mode_q;
				r[CSS_CTRL_RECOV_BIT] = recov_q;
			end
			CSS_OFF_CLOSED_PERIOD: r[15:0] = per_closed_q;
			CSS_OFF_OPEN_PERIOD: r[15:0] = per_open_q;
			CSS_OFF_OBJ_CFG: begin
				r[CSS_CFG_EN_LSB +: 4] = en_q;
				r[CSS_CFG_CYC_CLOSED_LSB +: 4] = cyc_closed_q;
				r[CSS_CFG_CYC_OPEN_LSB +: 4] = cyc_open_q;
				r[CSS_CFG_SND_CLOSED_LSB +: 4] = snd_closed_q;
				r[CSS_CFG_SND_OPEN_LSB +: 4] = snd_open_q;
			end
			CSS_OFF_STATUS: begin
				r[CSS_ST_CONTACT_BIT] = contact_s;
				r[CSS_ST_SAVED_BIT] = saved_contact_q;
				r[CSS_ST_LASTOP_BIT] = last_op_q;
				r[CSS_ST_CYC_BIT] = cyc_on_q;
				r[CSS_ST_EVT_BIT] = evt_q;
				r[CSS_ST_BUSY_BIT] = (st_q == CSS_ST_RUN);
				r[CSS_ST_IDX_LSB +: 2] = idx_q;
				r[CSS_ST_POWER_BIT] = power_s;
			end
			default: begin
				if (a >= CSS_OFF_DELAY_A && a <= CSS_OFF_DELAY_D && a[1:0] == 2'b00) begin
					r[15:0] = delay_q[a[3:2]];
				end
			end
		endcase
		reg_read = r;
	endfunction

	// ahb-lite slave: zero wait states, always okay, writes land in the data phase
	always_comb begin
		dp_wr_d = 1'b0;
		dp_addr_d = dp_addr_q;
		hrdata_d = hrdata_q;
		hreadyout_d = 1'b1;
		hresp_d = 1'b0;
		mode_d = mode_q;
		recov_d = recov_q;
		per_closed_d = per_closed_q;
		per_open_d = per_open_q;
		en_d = en_q;
		cyc_closed_d = cyc_closed_q;
		cyc_open_d = cyc_open_q;
		snd_closed_d = snd_closed_q;
		snd_open_d = snd_open_q;
		delay_d = delay_q;
		if (hsel_i && hready_i && htrans_i[CSS_HTRANS_ACTIVE_BIT]) begin
			dp_wr_d = hwrite_i;
			dp_addr_d = haddr_i[7:0];
			if (!hwrite_i) begin
				hrdata_d = reg_read(haddr_i[7:0]);
			end
		end
		if (dp_wr_q) begin
			case (dp_addr_q)
				CSS_OFF_CTRL: begin
					mode_d = hwdata_i[CSS_CTRL_MODE_BIT];
					recov_d = hwdata_i[CSS_CTRL_RECOV_BIT];
				end
				CSS_OFF_CLOSED_PERIOD: per_closed_d = clamp_period(hwdata_i);
				CSS_OFF_OPEN_PERIOD: per_open_d = clamp_period(hwdata_i);
				CSS_OFF_OBJ_CFG: begin
					en_d = hwdata_i[CSS_CFG_EN_LSB +: 4] | CSS_EN_FORCED;
					cyc_closed_d = hwdata_i[CSS_CFG_CYC_CLOSED_LSB +: 4];
					cyc_open_d = hwdata_i[CSS_CFG_CYC_OPEN_LSB +: 4];
					snd_closed_d = hwdata_i[CSS_CFG_SND_CLOSED_LSB +: 4];
					snd_open_d = hwdata_i[CSS_CFG_SND_OPEN_LSB +: 4];
				end
				default: begin
					if (dp_addr_q >= CSS_OFF_DELAY_A && dp_addr_q <= CSS_OFF_DELAY_D && dp_addr_q[1:0] == 2'b00) begin
						delay_d[dp_addr_q[3:2]] = hwdata_i[15:0];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			dp_wr_q <= 1'b0;
			dp_addr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			mode_q <= CSS_MODE_EDGES;
			recov_q <= CSS_RECOV_IGNORE;
			per_closed_q <= CSS_PERIOD_RESET;
			per_open_q <= CSS_PERIOD_RESET;
			en_q <= CSS_EN_RESET;
			cyc_closed_q <= CSS_CYC_RESET;
			cyc_open_q <= CSS_CYC_RESET;
			snd_closed_q <= CSS_SND_CLOSED_RESET;
			snd_open_q <= CSS_SND_OPEN_RESET;
			for (int i = 0; i < CSS_NUM_OBJ; i++) begin
				delay_q[i] <= CSS_DELAY_RESET;
			end
		end else begin
			dp_wr_q <= dp_wr_d;
			dp_addr_q <= dp_addr_d;
			hrdata_q <= hrdata_d;
			hreadyout_q <= hreadyout_d;
			hresp_q <= hresp_d;
			mode_q <= mode_d;
			recov_q <= recov_d;
			per_closed_q <= per_closed_d;
			per_open_q <= per_open_d;
			en_q <= en_d;
			cyc_closed_q <= cyc_closed_d;
			cyc_open_q <= cyc_open_d;
			snd_closed_q <= snd_closed_d;
			snd_open_q <= snd_open_d;
			delay_q <= delay_d;
		end
	end

	// event recognition, recovery, sequence stepping and cyclic replay
	always_comb begin
		logic start;
		logic s_evt;
		logic s_full;
		logic s_nodelay;
		logic [3:0] snd;
		logic [3:0] cyc;
		logic [1:0] nxt;
		start = 1'b0;
		s_evt = CSS_EVT_CLOSED;
		s_full = 1'b1;
		s_nodelay = 1'b0;
		snd = 4'h0;
		cyc = 4'h0;
		nxt = 2'b00;
		st_d = st_q;
		evt_d = evt_q;
		full_d = full_q;
		nodelay_d = nodelay_q;
		idx_d = idx_q;
		dly_d = dly_q;
		cyc_on_d = cyc_on_q;
		cyc_cnt_d = cyc_cnt_q;
		saved_contact_d = saved_contact_q;
		saved_valid_d = saved_valid_q;
		last_op_d = last_op_q;
		op_valid_d = op_valid_q;
		contact_prev_d = contact_s;
		power_prev_d = power_s;
		tx_valid_d = 1'b0;
		tx_obj_d = tx_obj_q;
		tx_event_d = tx_event_q;
		tx_cyclic_d = tx_cyclic_q;
		tick_restart = 1'b0;

		// fresh events, or recovery at voltage return, while voltage is present
		if (power_s && mode_q == CSS_MODE_EDGES && contact_s != contact_prev_q) begin
			start = 1'b1;
			s_evt = contact_s ? CSS_EVT_CLOSED : CSS_EVT_OPEN;
			saved_contact_d = contact_s;
			saved_valid_d = 1'b1;
		end else if (power_s && mode_q == CSS_MODE_SHORTLONG && (short_op_i || long_op_i)) begin
			start = 1'b1;
			s_evt = long_op_i ? CSS_EVT_OPEN : CSS_EVT_CLOSED;
			last_op_d = s_evt;
			op_valid_d = 1'b1;
		end else if (power_s && !power_prev_q && recov_q == CSS_RECOV_EVALUATE) begin
			if (mode_q == CSS_MODE_EDGES && saved_valid_q) begin
				start = 1'b1;
				if (contact_s == saved_contact_q) begin
					s_evt = saved_contact_q ? CSS_EVT_CLOSED : CSS_EVT_OPEN;
					s_full = 1'b0;
					s_nodelay = 1'b1;
				end else begin
					s_evt = contact_s ? CSS_EVT_CLOSED : CSS_EVT_OPEN;
					saved_contact_d = contact_s;
				end
			end else if (mode_q == CSS_MODE_SHORTLONG && op_valid_q) begin
				start = 1'b1;
				s_evt = last_op_q;
				s_full = 1'b0;
				s_nodelay = 1'b1;
			end
		end

		if (!power_s) begin
			// voltage gone: stop, keep the remembered status
			st_d = CSS_ST_IDLE;
			cyc_on_d = 1'b0;
		end else if (start) begin
			snd = pick4(s_evt, snd_closed_q, snd_open_q);
			cyc = pick4(s_evt, cyc_closed_q, cyc_open_q);
			tick_restart = 1'b1;
			st_d = CSS_ST_RUN;
			evt_d = s_evt;
			full_d = s_full;
			nodelay_d = s_nodelay;
			idx_d = 2'b00;
			dly_d = (s_nodelay || !will_send(en_q, snd, cyc, s_full, 2'b00)) ? 16'h0000 : delay_q[0];
			cyc_on_d = |(en_q & snd & cyc);
			cyc_cnt_d = s_evt ? per_open_q : per_closed_q;
		end else begin
			snd = pick4(evt_q, snd_closed_q, snd_open_q);
			cyc = pick4(evt_q, cyc_closed_q, cyc_open_q);
			if (cyc_on_q && tick && cyc_cnt_q <= CSS_PERIOD_MIN) begin
				// period over: replay the cyclic objects with their delays
				st_d = CSS_ST_RUN;
				full_d = 1'b0;
				nodelay_d = 1'b0;
				idx_d = 2'b00;
				dly_d = will_send(en_q, snd, cyc, 1'b0, 2'b00) ? delay_q[0] : 16'h0000;
				cyc_cnt_d = evt_q ? per_open_q : per_closed_q;
			end else begin
				if (cyc_on_q && tick) begin
					cyc_cnt_d = cyc_cnt_q - 16'h0001;
				end
				if (st_q == CSS_ST_RUN) begin
					if (dly_q == 16'h0000) begin
						if (will_send(en_q, snd, cyc, full_q, idx_q)) begin
							tx_valid_d = 1'b1;
							tx_obj_d = idx_q;
							tx_event_d = evt_q;
							tx_cyclic_d = !full_q;
						end
						if (idx_q == 2'b11) begin
							st_d = CSS_ST_IDLE;
						end else begin
							nxt = idx_q + 2'b01;
							idx_d = nxt;
							dly_d = (nodelay_q || !will_send(en_q, snd, cyc, full_q, nxt)) ? 16'h0000 : delay_q[nxt];
						end
					end else if (tick) begin
						dly_d = dly_q - 16'h0001;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			st_q <= CSS_ST_IDLE;
			evt_q <= CSS_EVT_CLOSED;
			full_q <= 1'b1;
			nodelay_q <= 1'b0;
			idx_q <= 2'b00;
			dly_q <= 16'h0000;
			cyc_on_q <= 1'b0;
			cyc_cnt_q <= CSS_PERIOD_RESET;
			saved_contact_q <= 1'b0;
			saved_valid_q <= 1'b0;
			last_op_q <= CSS_EVT_CLOSED;
			op_valid_q <= 1'b0;
			contact_prev_q <= 1'b0;
			power_prev_q <= 1'b0;
			tx_valid_q <= 1'b0;
			tx_obj_q <= 2'b00;
			tx_event_q <= CSS_EVT_CLOSED;
			tx_cyclic_q <= 1'b0;
		end else begin
			st_q <= st_d;
			evt_q <= evt_d;
			full_q <= full_d;
			nodelay_q <= nodelay_d;
			idx_q <= idx_d;
			dly_q <= dly_d;
			cyc_on_q <= cyc_on_d;
			cyc_cnt_q <= cyc_cnt_d;
			saved_contact_q <= saved_contact_d;
			saved_valid_q <= saved_valid_d;
			last_op_q <= last_op_d;
			op_valid_q <= op_valid_d;
			contact_prev_q <= contact_prev_d;
			power_prev_q <= power_prev_d;
			tx_valid_q <= tx_valid_d;
			tx_obj_q <= tx_obj_d;
			tx_event_q <= tx_event_d;
			tx_cyclic_q <= tx_cyclic_d;
		end
	end

	// outputs straight from flip-flops
	assign hrdata_o = hrdata_q;
	assign hreadyout_o = hreadyout_q;
	assign hresp_o = hresp_q;
	assign tx_valid_o = tx_valid_q;
	assign tx_obj_o = tx_obj_q;
	assign tx_event_o = tx_event_q;
	assign tx_cyclic_o = tx_cyclic_q;
endmodule

// File: include/css_pkg.sv
// constants and types shared by the contact sequence sender
package css_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] CSS_OFF_CTRL = 8'h00;
	localparam logic [7:0] CSS_OFF_CLOSED_PERIOD = 8'h04;
	localparam logic [7:0] CSS_OFF_OPEN_PERIOD = 8'h08;
	localparam logic [7:0] CSS_OFF_OBJ_CFG = 8'h0c;
	localparam logic [7:0] CSS_OFF_DELAY_A = 8'h10;
	localparam logic [7:0] CSS_OFF_DELAY_D = 8'h1c;
	localparam logic [7:0] CSS_OFF_STATUS = 8'h20;

	// control register fields
	localparam int CSS_CTRL_MODE_BIT = 0;
	localparam int CSS_CTRL_RECOV_BIT = 1;

	// object configuration fields, four bits each, bit n is object n (a..d)
	localparam int CSS_CFG_EN_LSB = 0;
	localparam int CSS_CFG_CYC_CLOSED_LSB = 4;
	localparam int CSS_CFG_CYC_OPEN_LSB = 8;
	localparam int CSS_CFG_SND_CLOSED_LSB = 12;
	localparam int CSS_CFG_SND_OPEN_LSB = 16;

	// status register fields
	localparam int CSS_ST_CONTACT_BIT = 0;
	localparam int CSS_ST_SAVED_BIT = 1;
	localparam int CSS_ST_LASTOP_BIT = 2;
	localparam int CSS_ST_CYC_BIT = 3;
	localparam int CSS_ST_EVT_BIT = 4;
	localparam int CSS_ST_BUSY_BIT = 5;
	localparam int CSS_ST_IDX_LSB = 6;
	localparam int CSS_ST_POWER_BIT = 8;

	// values after reset, field encodings and limits
	localparam logic CSS_MODE_EDGES = 1'b0;
	localparam logic CSS_MODE_SHORTLONG = 1'b1;
	localparam logic CSS_RECOV_IGNORE = 1'b0;
	localparam logic CSS_RECOV_EVALUATE = 1'b1;
	localparam logic [15:0] CSS_PERIOD_RESET = 16'h000f;
	localparam logic [15:0] CSS_PERIOD_MIN = 16'h0001;
	localparam logic [3:0] CSS_EN_RESET = 4'h1;
	localparam logic [3:0] CSS_EN_FORCED = 4'h1;
	localparam logic [3:0] CSS_CYC_RESET = 4'h0;
	localparam logic [3:0] CSS_SND_CLOSED_RESET = 4'h1;
	localparam logic [3:0] CSS_SND_OPEN_RESET = 4'h0;
	localparam logic [15:0] CSS_DELAY_RESET = 16'h0000;
	localparam int CSS_NUM_OBJ = 4;

	// event codes: closed contact or short operation, open contact or long operation
	localparam logic CSS_EVT_CLOSED = 1'b0;
	localparam logic CSS_EVT_OPEN = 1'b1;

	// one-second time base
	localparam longint CSS_CLK_PERIOD_NS = 10;
	localparam longint CSS_TICK_PERIOD_S = 1;
	localparam int unsigned CSS_TICK_CYCLES = 32'((CSS_TICK_PERIOD_S * 64'd1000000000) / CSS_CLK_PERIOD_NS);
	localparam logic [31:0] CSS_TICK_CNT_RESET = 32'h0000_0000;

	// ahb-lite transfer type bit that marks an active transfer
	localparam int CSS_HTRANS_ACTIVE_BIT = 1;

	// sequencer states
	typedef enum logic [0:0] {
		CSS_ST_IDLE,
		CSS_ST_RUN
	} css_seq_state_t;
endpackage

// File: hw/css_sync2.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module css_sync2 (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// level in and out
	input wire logic async_i,
	output logic sync_o
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	// first stage feeds only the second stage
	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;
endmodule

// File: hw/css_sec_tick.sv
// one-second tick generator with a restart input
`timescale 1ns/100ps
module css_sec_tick import css_pkg::*; #(
	parameter int unsigned TICK_CYCLES = CSS_TICK_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// restart the second so that it starts counting now
	input wire logic restart_i,
	// one-cycle pulse once per second
	output logic tick_o
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic tick_q;
	logic tick_d;

	// count clock cycles, pulse on the last one of each second
	always_comb begin
		cnt_d = cnt_q + 32'h0000_0001;
		tick_d = 1'b0;
		if (restart_i) begin
			cnt_d = CSS_TICK_CNT_RESET;
		end else if (cnt_q >= TICK_CYCLES - 1) begin
			cnt_d = CSS_TICK_CNT_RESET;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			cnt_q <= CSS_TICK_CNT_RESET;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick_o = tick_q;
endmodule

// File: tb/css_contact_sequence_sender_assertions.sv
// port checker for the contact sequence sender
`timescale 1ns/100ps
module css_contact_sequence_sender_assertions import css_pkg::*; #(
	parameter int unsigned TICK_CYCLES = CSS_TICK_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	// events and voltage
	input wire logic contact_closed_i,
	input wire logic short_op_i,
	input wire logic long_op_i,
	input wire logic power_ok_i,
	// telegram requests
	input wire logic tx_valid_o,
	input wire logic [1:0] tx_obj_o,
	input wire logic tx_event_o,
	input wire logic tx_cyclic_o
);
	logic wr_q;
	logic [7:0] wa_q;
	logic mode_q;
	logic [19:0] cfg_q;
	logic dly0_q;
	logic [3:0] pwr_q;
	logic [3:0] en_w;
	logic [3:0] snd_w;
	logic [3:0] cyc_w;
	logic rd_take;
	default clocking dcb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	// shadow of the writes that shape a pass, and a count of steady voltage
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			mode_q <= CSS_MODE_EDGES;
			cfg_q <= 20'h01001;
			dly0_q <= 1'b1;
			pwr_q <= 4'h0;
		end else begin
			wr_q <= hsel_i & hready_i & htrans_i[CSS_HTRANS_ACTIVE_BIT] & hwrite_i;
			wa_q <= haddr_i[7:0];
			pwr_q <= !power_ok_i ? 4'h0 : (pwr_q == 4'hf ? pwr_q : pwr_q + 4'h1);
			if (wr_q && wa_q == CSS_OFF_CTRL) mode_q <= hwdata_i[CSS_CTRL_MODE_BIT];
			if (wr_q && wa_q == CSS_OFF_OBJ_CFG) cfg_q <= hwdata_i[19:0];
			if (wr_q && wa_q == CSS_OFF_DELAY_A) dly0_q <= (hwdata_i[15:0] == 16'h0000);
		end
	end
	// configuration fields of the event being sent
	assign en_w = cfg_q[CSS_CFG_EN_LSB +: 4] | CSS_EN_FORCED;
	assign snd_w = tx_event_o ? cfg_q[CSS_CFG_SND_OPEN_LSB +: 4] : cfg_q[CSS_CFG_SND_CLOSED_LSB +: 4];
	assign cyc_w = tx_event_o ? cfg_q[CSS_CFG_CYC_OPEN_LSB +: 4] : cfg_q[CSS_CFG_CYC_CLOSED_LSB +: 4];
	assign rd_take = hsel_i & hready_i & htrans_i[CSS_HTRANS_ACTIVE_BIT] & !hwrite_i;
	// steps of a pass that opens with object a
	sequence s_close_edge;
		!mode_q && cfg_q[CSS_CFG_SND_CLOSED_LSB] && dly0_q && pwr_q == 4'hf && $rose(contact_closed_i);
	endsequence
	sequence s_short_op;
		mode_q && cfg_q[CSS_CFG_SND_CLOSED_LSB] && dly0_q && pwr_q == 4'hf && short_op_i && !long_op_i;
	endsequence
	sequence s_first_obj;
		tx_valid_o && tx_obj_o == 2'd0 && tx_event_o == CSS_EVT_CLOSED;
	endsequence
	a_bus_okay: assert property (hreadyout_o && !hresp_o)
		else $error("slave not ready or not okay");
	a_rdata_stands: assert property (!rd_take |=> $stable(hrdata_o))
		else $error("read data moved without a read");
	a_tx_fields_hold: assert property (!tx_valid_o |-> $stable({tx_obj_o, tx_event_o, tx_cyclic_o}))
		else $error("telegram fields moved without a send");
	a_send_configured: assert property (tx_valid_o && !tx_cyclic_o |-> en_w[tx_obj_o] && snd_w[tx_obj_o])
		else $error("object sent that is not set to send");
	a_cyclic_configured: assert property (tx_valid_o && tx_cyclic_o |-> en_w[tx_obj_o] && snd_w[tx_obj_o] && cyc_w[tx_obj_o])
		else $error("non-cyclic object sent in a cyclic pass");
	a_quiet_unpowered: assert property (!power_ok_i [*5] |-> !tx_valid_o)
		else $error("telegram sent without voltage");
	a_close_first_obj: assert property (s_close_edge |-> ##[4:6] s_first_obj)
		else $error("closing edge did not send object a in time");
	a_short_first_obj: assert property (s_short_op |-> ##[2:4] s_first_obj)
		else $error("short operation did not send object a in time");
endmodule
bind css_contact_sequence_sender css_contact_sequence_sender_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .contact_closed_i(contact_closed_i), .short_op_i(short_op_i),
	.long_op_i(long_op_i), .power_ok_i(power_ok_i), .tx_valid_o(tx_valid_o), .tx_obj_o(tx_obj_o),
	.tx_event_o(tx_event_o), .tx_cyclic_o(tx_cyclic_o));

// File: tb/css_bus_actuator.sv
// bus actuator model that logs every telegram request
`timescale 1ns/100ps
module css_bus_actuator (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// telegram requests
	input wire logic tx_valid_i,
	input wire logic [1:0] tx_obj_i,
	input wire logic tx_event_i,
	input wire logic tx_cyclic_i
);
	logic [3:0] rx_word_q[$];
	int rx_time_q[$];
	int cyc_cnt = 0;
	// log each one-cycle request in the cycle it stands
	always @(posedge clk_sys_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (!reset_i && tx_valid_i === 1'b1) begin
			rx_word_q.push_back({tx_cyclic_i, tx_event_i, tx_obj_i});
			rx_time_q.push_back(cyc_cnt);
		end
	end
endmodule

// File: tb/css_contact_sequence_sender_test.sv
// self-checking bench for the contact sequence sender
`timescale 1ns/100ps
module css_contact_sequence_sender_test import css_pkg::*;;
	localparam int TICKS = 10;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0;
	logic [31:0] hrdata_o;
	logic hreadyout_o;
	logic hresp_o;
	logic contact_closed_i = 1'b0;
	logic short_op_i = 1'b0;
	logic long_op_i = 1'b0;
	logic power_ok_i = 1'b1;
	logic tx_valid_o;
	logic [1:0] tx_obj_o;
	logic tx_event_o;
	logic tx_cyclic_o;
	logic [19:0] cfg;
	logic op;
	int error_cnt = 0;
	int samples_checked = 0;
	int cycles = 0;
	int t0;
	int t_last;
	always #5 clk_sys_i = ~clk_sys_i;
	css_contact_sequence_sender #(.TICK_CYCLES(TICKS)) u_dut (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
		.hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .contact_closed_i(contact_closed_i),
		.short_op_i(short_op_i), .long_op_i(long_op_i), .power_ok_i(power_ok_i), .tx_valid_o(tx_valid_o),
		.tx_obj_o(tx_obj_o), .tx_event_o(tx_event_o), .tx_cyclic_o(tx_cyclic_o));
	css_bus_actuator u_act (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .tx_valid_i(tx_valid_o),
		.tx_obj_i(tx_obj_o), .tx_event_i(tx_event_o), .tx_cyclic_i(tx_cyclic_o));
	// verdict and end of run
	task automatic final_report();
		$display("checked %0d, mismatched %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// cut a hang short
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt = error_cnt + 1;
			final_report();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	// one ahb-lite single transfer, held until hready is sampled high
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel_i <= 1'b1;
		htrans_i <= 2'b10;
		haddr_i <= {24'h0, a};
		hwrite_i <= wr;
		do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'b00;
		hwdata_i <= d;
		do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
		q = hrdata_o;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask
	// objects a pass should send for a configuration
	function automatic logic [3:0] pass_mask(input logic [19:0] c, input logic ev, input logic cyc_only);
		logic [3:0] snd;
		logic [3:0] cyc;
		snd = ev ? c[CSS_CFG_SND_OPEN_LSB +: 4] : c[CSS_CFG_SND_CLOSED_LSB +: 4];
		cyc = ev ? c[CSS_CFG_CYC_OPEN_LSB +: 4] : c[CSS_CFG_CYC_CLOSED_LSB +: 4];
		return (c[CSS_CFG_EN_LSB +: 4] | 4'h1) & snd & (cyc_only ? cyc : 4'hf);
	endfunction
	// pop the logged telegrams of one pass, in object order
	task automatic expect_pass(input logic [3:0] mask, input logic ev, input logic cyc);
		for (int i = 0; i < 4; i++) begin
			if (mask[i] && u_act.rx_word_q.size() == 0) check(32'hffff, 32'(i));
			else if (mask[i]) begin
				check({28'h0, u_act.rx_word_q.pop_front()}, {28'h0, cyc, ev, 2'(i)});
				t_last = u_act.rx_time_q.pop_front();
			end
		end
	endtask
	// voltage loss with the contact driven to the given level while off, then return
	task automatic pwr_cycle(input logic contact);
		power_ok_i <= 1'b0;
		wait_cyc(10);
		contact_closed_i <= contact;
		wait_cyc(20);
		check(32'(u_act.rx_word_q.size()), 32'h0);
		power_ok_i <= 1'b1;
		t0 = u_act.cyc_cnt;
		wait_cyc(40);
	endtask
	initial begin
		void'($urandom(64141));
		wait_cyc(16);
		reset_i <= 1'b0;
		wait_cyc(2);
		rdchk(CSS_OFF_CTRL, 32'h0);
		rdchk(CSS_OFF_CLOSED_PERIOD, 32'hf);
		rdchk(CSS_OFF_OPEN_PERIOD, 32'hf);
		rdchk(CSS_OFF_OBJ_CFG, 32'h1001);
		for (int i = 0; i < 4; i++) rdchk(CSS_OFF_DELAY_A + 8'(4 * i), 32'h0);
		rdchk(8'h24, 32'h0);
		wr(CSS_OFF_CLOSED_PERIOD, 32'h0);
		rdchk(CSS_OFF_CLOSED_PERIOD, 32'h1);
		wr(CSS_OFF_OPEN_PERIOD, 32'hffff);
		rdchk(CSS_OFF_OPEN_PERIOD, 32'hffff);
		t0 = int'($urandom_range(65535, 1));
		wr(CSS_OFF_CLOSED_PERIOD, 32'(t0));
		rdchk(CSS_OFF_CLOSED_PERIOD, 32'(t0));
		$display("test registers done");
		// closing pass with delays, one replay, then the opening edge ends it
		cfg = 20'h4b0af;
		wr(CSS_OFF_OBJ_CFG, {12'h0, cfg});
		wr(CSS_OFF_DELAY_A + 8'h4, 32'h1);
		wr(CSS_OFF_DELAY_D, 32'h1);
		wr(CSS_OFF_CLOSED_PERIOD, 32'h6);
		contact_closed_i <= 1'b1;
		wait_cyc(100);
		expect_pass(pass_mask(cfg, CSS_EVT_CLOSED, 1'b0), CSS_EVT_CLOSED, 1'b0);
		t0 = t_last;
		expect_pass(pass_mask(cfg, CSS_EVT_CLOSED, 1'b1), CSS_EVT_CLOSED, 1'b1);
		check(32'(t_last - t0 >= 6 * TICKS - 2 && t_last - t0 <= 6 * TICKS + 2), 32'h1);
		contact_closed_i <= 1'b0;
		wait_cyc(200);
		expect_pass(pass_mask(cfg, CSS_EVT_OPEN, 1'b0), CSS_EVT_OPEN, 1'b0);
		check(32'(u_act.rx_word_q.size()), 32'h0);
		$display("test edge_cyclic done");
		// random configurations in short/long mode
		wr(CSS_OFF_CTRL, 32'h1);
		wr(CSS_OFF_CLOSED_PERIOD, 32'hffff);
		wr(CSS_OFF_DELAY_A + 8'h4, 32'h0);
		wr(CSS_OFF_DELAY_D, 32'h0);
		repeat (6) begin
			cfg = 20'($urandom);
			op = 1'($urandom);
			wr(CSS_OFF_OBJ_CFG, {12'h0, cfg});
			short_op_i <= !op;
			long_op_i <= op;
			wait_cyc(1);
			short_op_i <= 1'b0;
			long_op_i <= 1'b0;
			wait_cyc(12);
			expect_pass(pass_mask(cfg, op, 1'b0), op, 1'b0);
			check(32'(u_act.rx_word_q.size()), 32'h0);
		end
		$display("test short_long done");
		// voltage return in edge mode: same status, changed status, ignore
		cfg = 20'h4b0af;
		wr(CSS_OFF_OBJ_CFG, {12'h0, cfg});
		wr(CSS_OFF_DELAY_A + 8'h4, 32'h1);
		wr(CSS_OFF_DELAY_D, 32'h1);
		wr(CSS_OFF_CLOSED_PERIOD, 32'h6);
		wr(CSS_OFF_CTRL, 32'h2);
		contact_closed_i <= 1'b1;
		wait_cyc(40);
		expect_pass(pass_mask(cfg, CSS_EVT_CLOSED, 1'b0), CSS_EVT_CLOSED, 1'b0);
		pwr_cycle(1'b1);
		expect_pass(pass_mask(cfg, CSS_EVT_CLOSED, 1'b1), CSS_EVT_CLOSED, 1'b1);
		check(32'(t_last - t0 < TICKS), 32'h1);
		pwr_cycle(1'b0);
		expect_pass(pass_mask(cfg, CSS_EVT_OPEN, 1'b0), CSS_EVT_OPEN, 1'b0);
		check(32'(u_act.rx_word_q.size()), 32'h0);
		wr(CSS_OFF_CTRL, 32'h0);
		pwr_cycle(1'b1);
		wait_cyc(20);
		check(32'(u_act.rx_word_q.size()), 32'h0);
		// voltage return in short/long mode restores the long operation
		cfg = 20'h4040f;
		wr(CSS_OFF_CTRL, 32'h3);
		wr(CSS_OFF_OBJ_CFG, {12'h0, cfg});
		long_op_i <= 1'b1;
		wait_cyc(1);
		long_op_i <= 1'b0;
		wait_cyc(12);
		expect_pass(pass_mask(cfg, CSS_EVT_OPEN, 1'b0), CSS_EVT_OPEN, 1'b0);
		pwr_cycle(1'b1);
		expect_pass(pass_mask(cfg, CSS_EVT_OPEN, 1'b1), CSS_EVT_OPEN, 1'b1);
		check(32'(u_act.rx_word_q.size()), 32'h0);
		$display("test recovery done");
		final_report();
	end
endmodule
